/* File: rtl/phu_defs.svh */
// hint encodings, attribute codes and field layout for the prefetch hint unit
// assumes inclusion by bare name from rtl files
`ifndef PHU_DEFS_SVH
`define PHU_DEFS_SVH
`define PHU_ADDR_W        32
`define PHU_OFFS_W        16
`define PHU_OFFS_SIGN     15
`define PHU_HINT_W        5
`define PHU_ATTR_W        3
`define PHU_ATTR_UNCACHED 3'h2
`define PHU_ATTR_UNC_ACC  3'h7
`define PHU_ATTR_COHER_A  3'h4
`define PHU_ATTR_COHER_B  3'h5
`define PHU_HINT_LOAD     5'h00
`define PHU_HINT_STORE    5'h01
`define PHU_HINT_LD_STRM  5'h04
`define PHU_HINT_ST_STRM  5'h05
`define PHU_HINT_LD_RETN  5'h06
`define PHU_HINT_ST_RETN  5'h07
`define PHU_HINT_WB_INV   5'h19
`define PHU_HINT_ZERO     5'h1E
`define PHU_OP_W          3
`define PHU_OP_NONE       3'h0
`define PHU_OP_FETCH      3'h1
`define PHU_OP_WB_INV     3'h2
`define PHU_OP_ZERO       3'h3
`define PHU_PLACE_W       2
`define PHU_PLACE_NORMAL  2'h0
`define PHU_PLACE_STREAM  2'h1
`define PHU_PLACE_RETAIN  2'h2
`endif

/* File: rtl/phu_pkg.sv */
// types shared by the prefetch hint unit files
// assumes phu_defs.svh is compiled alongside
`include "phu_defs.svh"
package phu_pkg;
  typedef enum logic [2:0] {
    PHU_IDLE = 3'h1,
    PHU_REQ  = 3'h2,
    PHU_WAIT = 3'h4
  } phu_state_t;
endpackage

/* File: rtl/phu_addr_gen.sv */
// effective address adder of the prefetch hint unit
// assumes base and offset are stable while valid is high, same clock
`timescale 1ns/1ps
`include "phu_defs.svh"
module phu_addr_gen (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     load,
  input  wire logic [`PHU_ADDR_W-1:0]   base,
  input  wire logic [`PHU_OFFS_W-1:0]   offset,
  output logic      [`PHU_ADDR_W-1:0]   eff_addr
);
  typedef struct packed {
    logic [`PHU_ADDR_W-1:0] addr;
  } phu_ag_t;
  phu_ag_t st;
  phu_ag_t next_st;
  logic [`PHU_ADDR_W-1:0] ext;
  always_comb begin
    ext = {{(`PHU_ADDR_W-`PHU_OFFS_W){offset[`PHU_OFFS_SIGN]}}, offset};
    next_st = st;
    if (load) begin
      next_st.addr = base + ext;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign eff_addr = st.addr;
endmodule

/* File: rtl/phu_hint_dec.sv */
// hint field decoder: turns 5-bit hint into cache operation and placement
// purely combinational, read by the core unit on the same clock
`timescale 1ns/1ps
`include "phu_defs.svh"
module phu_hint_dec (
  input  wire logic [`PHU_HINT_W-1:0]  hint,
  output logic      [`PHU_OP_W-1:0]    op,
  output logic                         is_store,
  output logic      [`PHU_PLACE_W-1:0] place
);
  always_comb begin
    op       = `PHU_OP_NONE;
    is_store = 1'b0;
    place    = `PHU_PLACE_NORMAL;
    case (hint)
      `PHU_HINT_LOAD: begin
        op = `PHU_OP_FETCH;
      end
      `PHU_HINT_STORE: begin
        op       = `PHU_OP_FETCH;
        is_store = 1'b1;
      end
      `PHU_HINT_LD_STRM: begin
        op    = `PHU_OP_FETCH;
        place = `PHU_PLACE_STREAM;
      end
      `PHU_HINT_ST_STRM: begin
        op       = `PHU_OP_FETCH;
        is_store = 1'b1;
        place    = `PHU_PLACE_STREAM;
      end
      `PHU_HINT_LD_RETN: begin
        op    = `PHU_OP_FETCH;
        place = `PHU_PLACE_RETAIN;
      end
      `PHU_HINT_ST_RETN: begin
        op       = `PHU_OP_FETCH;
        is_store = 1'b1;
        place    = `PHU_PLACE_RETAIN;
      end
      `PHU_HINT_WB_INV: begin
        op = `PHU_OP_WB_INV;
      end
      `PHU_HINT_ZERO: begin
        op       = `PHU_OP_ZERO;
        is_store = 1'b1;
      end
      // reserved and free codes stay no-op: no private meaning given
      default: begin
        op = `PHU_OP_NONE;
      end
    endcase
  end
endmodule

/* File: rtl/phu_core.sv */
// Notes on behaviour
// - address is base plus sign-extended offset
// - no visible change except zero fill
// - faulting address raises nothing, moves nothing
// - faulting prefetch may still write back
// - side-effect errors reported only if enabled
// - uncached type issues no cache operation
// - operation carries address attribute like load
// - cached fetch requests block holding address
// - coherent attribute marks coherent transaction
// - completes under barrier ordering, waits acknowledge
// - hint 0 load, 1 store fetch
// - hints 4,5 streamed placement
// - hints 6,7 retained placement
// - reserved hints given no meaning
// - free hints left as no-op
// - hint 25 write back dirty then invalidate
// - hint 25 skips locked lines
// - hint 30 zero fills on miss only
// - no hint touches a locked line
//
// prefetch hint unit: top level, issues at most one cache request per prefetch
// assumes translation result arrives with the instruction, same clock
`timescale 1ns/1ps
`include "phu_defs.svh"
module phu_core (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     pf_valid,
  input  wire logic [`PHU_ADDR_W-1:0]   pf_base,
  input  wire logic [`PHU_OFFS_W-1:0]   pf_offset,
  input  wire logic [`PHU_HINT_W-1:0]   pf_hint,
  input  wire logic                     xlate_fault,
  input  wire logic [`PHU_ATTR_W-1:0]   cache_coherency_attr,
  input  wire logic                     err_report_en,
  input  wire logic                     cache_ready,
  input  wire logic                     cache_done,
  input  wire logic                     cache_err,
  output logic                          pf_busy,
  output logic                          pf_done,
  output logic                          pf_err,
  output logic                          cache_req,
  output logic      [`PHU_OP_W-1:0]     cache_op,
  output logic      [`PHU_ADDR_W-1:0]   cache_addr,
  output logic                          cache_store,
  output logic      [`PHU_PLACE_W-1:0]  cache_place,
  output logic                          cache_coherent,
  output logic      [`PHU_ATTR_W-1:0]   cache_attr,
  output logic                          cache_skip_locked,
  output logic                          cache_wb_only
);
  // ==========================================================
  // state
  typedef struct packed {
    phu_pkg::phu_state_t      fsm;
    logic                     busy;
    logic                     done;
    logic                     err;
    logic                     req;
    logic [`PHU_OP_W-1:0]     op;
    logic                     store;
    logic [`PHU_PLACE_W-1:0]  place;
    logic                     coherent;
    logic [`PHU_ATTR_W-1:0]   attr;
    logic                     wb_only;
    logic                     pend;
    logic                     skip_lock;
  } phu_core_t;

  phu_core_t                st;
  phu_core_t                next_st;
  logic [`PHU_ADDR_W-1:0]   eff_addr;
  logic [`PHU_OP_W-1:0]     dec_op;
  logic                     dec_store;
  logic [`PHU_PLACE_W-1:0]  dec_place;
  logic                     accept;
  logic                     uncached;
  logic                     coherent;

  // ==========================================================
  // address and hint decode
  phu_addr_gen u_addr (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (accept),
    .base     (pf_base),
    .offset   (pf_offset),
    .eff_addr (eff_addr)
  );

  phu_hint_dec u_dec (
    .hint     (pf_hint),
    .op       (dec_op),
    .is_store (dec_store),
    .place    (dec_place)
  );

  // ==========================================================
  // next state
  always_comb begin
    accept   = pf_valid && (st.fsm == phu_pkg::PHU_IDLE);
    uncached = (cache_coherency_attr == `PHU_ATTR_UNCACHED) ||
               (cache_coherency_attr == `PHU_ATTR_UNC_ACC);
    coherent = (cache_coherency_attr == `PHU_ATTR_COHER_A) ||
               (cache_coherency_attr == `PHU_ATTR_COHER_B);
    next_st      = st;
    next_st.done = 1'b0;
    next_st.err  = 1'b0;
    // locked lines are left alone by every operation
    next_st.skip_lock = 1'b1;
    case (st.fsm)
      phu_pkg::PHU_IDLE: begin
        if (accept) begin
          next_st.op       = dec_op;
          next_st.store    = dec_store;
          next_st.place    = dec_place;
          next_st.attr     = cache_coherency_attr;
          next_st.coherent = coherent;
          next_st.wb_only  = 1'b0;
          next_st.pend     = 1'b1;
          if (uncached) begin
            next_st.pend = 1'b0;
          end else if (dec_op == `PHU_OP_NONE) begin
            next_st.pend = 1'b0;
          end else if (xlate_fault) begin
            // fault is swallowed; only an invisible writeback survives
            if (dec_op == `PHU_OP_WB_INV) begin
              next_st.wb_only = 1'b1;
            end else begin
              next_st.pend = 1'b0;
            end
          end
          if (next_st.pend) begin
            next_st.fsm  = phu_pkg::PHU_REQ;
            next_st.busy = 1'b1;
            next_st.req  = 1'b1;
          end else begin
            // completes at once, nothing architectural touched
            next_st.done = 1'b1;
          end
        end
      end
      phu_pkg::PHU_REQ: begin
        if (cache_ready) begin
          next_st.req = 1'b0;
          next_st.fsm = phu_pkg::PHU_WAIT;
        end
      end
      phu_pkg::PHU_WAIT: begin
        // hold busy until the hierarchy acknowledges completion
        if (cache_done) begin
          next_st.fsm  = phu_pkg::PHU_IDLE;
          next_st.busy = 1'b0;
          next_st.pend = 1'b0;
          next_st.done = 1'b1;
          next_st.err  = cache_err && err_report_en;
        end
      end
      default: begin
        next_st.fsm  = phu_pkg::PHU_IDLE;
        next_st.busy = 1'b0;
        next_st.req  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st          <= '0;
      st.fsm      <= phu_pkg::PHU_IDLE;
      st.skip_lock <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign pf_busy           = st.busy;
  assign pf_done           = st.done;
  assign pf_err            = st.err;
  assign cache_req         = st.req;
  assign cache_op          = st.op;
  assign cache_addr        = eff_addr;
  assign cache_store       = st.store;
  assign cache_place       = st.place;
  assign cache_coherent    = st.coherent;
  assign cache_attr        = st.attr;
  assign cache_skip_locked = st.skip_lock;
  assign cache_wb_only     = st.wb_only;
endmodule

/* File: sim/phu_cache_model.sv */
// far-side cache model: grants requests, reports completion
// assumes one request at a time, same clock as the unit
`timescale 1ns/1ps
module phu_cache_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic cache_req,
  input  wire logic slow,
  input  wire logic bad,
  output logic      cache_ready,
  output logic      cache_done,
  output logic      cache_err
);
  // ======================
  // grant and completion
  logic [1:0] cnt;
  logic       hs;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt         <= 2'h0;
      hs          <= 1'b0;
      cache_ready <= 1'b0;
      cache_done  <= 1'b0;
      cache_err   <= 1'b0;
    end else begin
      hs          <= cache_req && cache_ready;
      cache_ready <= cache_req && !cache_ready && (!slow || cnt == 2'h3);
      cnt         <= (cache_req && !cache_ready) ? cnt + 2'h1 : 2'h0;
      cache_done  <= hs;
      // error toggles outside completion so nothing may lean on it
      cache_err   <= hs ? bad : !cache_err;
    end
  end
endmodule

/* File: sim/phu_props.sv */
// port assertions for the prefetch hint unit
// assumes one clock domain, bound to phu_core at the foot
`timescale 1ns/1ps
module phu_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        pf_valid,
  input wire logic [31:0] pf_base,
  input wire logic [15:0] pf_offset,
  input wire logic [4:0]  pf_hint,
  input wire logic        xlate_fault,
  input wire logic [2:0]  cache_coherency_attr,
  input wire logic        err_report_en,
  input wire logic        cache_ready,
  input wire logic        cache_done,
  input wire logic        cache_err,
  input wire logic        pf_busy,
  input wire logic        pf_done,
  input wire logic        pf_err,
  input wire logic        cache_req,
  input wire logic [2:0]  cache_op,
  input wire logic [31:0] cache_addr,
  input wire logic        cache_coherent,
  input wire logic [2:0]  cache_attr,
  input wire logic        cache_skip_locked,
  input wire logic        cache_wb_only
);
  // =========
  // helpers
  logic        acc, unc, live, go;
  logic [31:0] ea;
  assign acc = pf_valid && !pf_busy;
  assign unc = cache_coherency_attr inside {3'h2, 3'h7};
  assign live = pf_hint inside {5'h00, 5'h01, [5'h04:5'h07], 5'h19, 5'h1E};
  // faulting writeback-invalidate still goes out, other faults drop
  assign go = acc && !unc && live && (!xlate_fault || pf_hint == 5'h19);
  assign ea = pf_base + {{16{pf_offset[15]}}, pf_offset};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_hs;
    cache_req && cache_ready;
  endsequence
  sequence s_fin;
    cache_done && pf_busy && !cache_req;
  endsequence
  // ============
  // properties
  issue_addr_a: assert property (
    go |=> cache_req && cache_addr == $past(ea))
    else $error("request or address wrong");
  nop_done_a: assert property (
    acc && !go |=> pf_done && !cache_req)
    else $error("dropped prefetch misbehaved");
  req_hold_a: assert property (cache_req && !cache_ready |=> cache_req)
    else $error("request withdrawn early");
  req_drop_a: assert property (s_hs |=> !cache_req && pf_busy)
    else $error("request not released");
  fin_done_a: assert property (s_fin |=> pf_done && !pf_busy)
    else $error("completion not reported");
  attr_echo_a: assert property (
    go |=> cache_attr == $past(cache_coherency_attr))
    else $error("attribute not carried");
  coher_mark_a: assert property (
    cache_req |-> cache_coherent == (cache_attr inside {3'h4, 3'h5}))
    else $error("coherent flag wrong");
  err_cause_a: assert property (
    pf_err |-> pf_done && $past(cache_err) && $past(err_report_en))
    else $error("error without cause");
  wb_only_a: assert property (
    go |=> cache_wb_only == $past(xlate_fault))
    else $error("writeback-only flag wrong");
  wb_op_a: assert property (cache_wb_only |-> cache_op == 3'h2)
    else $error("writeback-only on wrong operation");
  skip_lock_a: assert property (cache_skip_locked)
    else $error("locked lines not protected");
endmodule
bind phu_core phu_props u_phu_props (.clk, .rst_b, .pf_valid, .pf_base,
  .pf_offset, .pf_hint, .xlate_fault, .cache_coherency_attr, .err_report_en,
  .cache_ready, .cache_done, .cache_err, .pf_busy, .pf_done, .pf_err,
  .cache_req, .cache_op, .cache_addr, .cache_coherent, .cache_attr,
  .cache_skip_locked, .cache_wb_only);

/* File: sim/tb.sv */
// self-checking bench for the prefetch hint unit
// assumes phu_core, phu_cache_model and phu_props compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic        clk = 0, rst_b = 0, pf_valid = 0, xlate_fault = 0;
  logic        err_report_en = 0, slow = 0, bad = 0, saw, ers;
  logic [31:0] pf_base = 32'h0000_1000;
  logic [15:0] pf_offset = 16'h0;
  logic [4:0]  pf_hint = 5'h0;
  logic [2:0]  cache_coherency_attr = 3'h3, cache_op, cache_attr;
  logic        cache_ready, cache_done, cache_err, pf_busy, pf_done, pf_err;
  logic        cache_req, cache_store, cache_coherent, cache_skip_locked;
  logic        cache_wb_only;
  logic [31:0] cache_addr;
  logic [1:0]  cache_place;
  int          n_mismatch = 0, checked = 0;
  always #10 clk = ~clk;
  phu_core u_phu_core (.clk, .rst_b, .pf_valid, .pf_base, .pf_offset,
    .pf_hint, .xlate_fault, .cache_coherency_attr, .err_report_en,
    .cache_ready, .cache_done, .cache_err, .pf_busy, .pf_done, .pf_err,
    .cache_req, .cache_op, .cache_addr, .cache_store, .cache_place,
    .cache_coherent, .cache_attr, .cache_skip_locked, .cache_wb_only);
  phu_cache_model u_phu_cache_model (.clk, .rst_b, .cache_req, .slow, .bad,
    .cache_ready, .cache_done, .cache_err);
  // ==========
  // tasks
  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pf(input logic [4:0] h, input logic [2:0] a,
                    input logic f, input logic [15:0] o);
    int n;
    @(posedge clk);
    #1;
    {pf_valid, pf_hint, cache_coherency_attr} = {1'b1, h, a};
    {xlate_fault, pf_offset, saw} = {f, o, 1'b0};
    @(posedge clk);
    #1;
    pf_valid = 1'b0;
    for (n = 0; n < 40 && pf_done !== 1'b1; n++) begin
      saw = saw | cache_req;
      @(posedge clk);
      #1;
    end
    if (n == 40) begin
      n_mismatch++;
      results();
    end
    ers = pf_err;
  endtask
  task automatic t_hints;
    logic [2:0] eo;
    for (int i = 0; i < 32; i++) begin
      case (i[4:0])
        5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07: eo = 3'h1;
        5'h19: eo = 3'h2;
        5'h1E: eo = 3'h3;
        default: eo = 3'h0;
      endcase
      pf(i[4:0], 3'h3, 1'b0, 16'h0);
      `CHK(saw, eo != 3'h0)
      if (saw) `CHK(cache_op, eo)
      if (eo == 3'h1) begin
        `CHK(cache_store, i[0])
        `CHK(cache_place, (i > 5) ? 2'h2 : (i > 3) ? 2'h1 : 2'h0)
      end
    end
  endtask
  task automatic t_addr;
    slow = 1'b1;
    pf_base = 32'h0000_0010;
    pf(5'h01, 3'h4, 1'b0, 16'hFFF0);
    `CHK(cache_addr, 32'h0000_0000)
    `CHK(cache_attr, 3'h4)
    pf_base = 32'h7FFF_FFF0;
    pf(5'h06, 3'h3, 1'b0, 16'h8000);
    `CHK(cache_addr, 32'h7FFF_7FF0)
    `CHK(cache_coherent, 1'b0)
    pf(5'h00, 3'h5, 1'b0, 16'h7FFF);
    `CHK(cache_addr, 32'h8000_7FEF)
    `CHK(cache_coherent, 1'b1)
    slow = 1'b0;
  endtask
  task automatic t_unc_fault;
    pf(5'h1E, 3'h2, 1'b0, 16'h0);
    `CHK(saw, 1'b0)
    pf(5'h00, 3'h7, 1'b0, 16'h0);
    `CHK(saw, 1'b0)
    pf(5'h1E, 3'h3, 1'b1, 16'h0);
    `CHK(saw, 1'b0)
    pf(5'h19, 3'h3, 1'b1, 16'h0);
    `CHK(saw, 1'b1)
    `CHK(cache_wb_only, 1'b1)
    `CHK(cache_op, 3'h2)
    `CHK(cache_skip_locked, 1'b1)
    pf(5'h1E, 3'h5, 1'b0, 16'h0);
    `CHK(saw, 1'b1)
    `CHK(cache_store, 1'b1)
    `CHK(cache_wb_only, 1'b0)
    `CHK(cache_skip_locked, 1'b1)
  endtask
  task automatic t_err;
    {bad, err_report_en} = 2'h3;
    pf(5'h00, 3'h3, 1'b0, 16'h0);
    `CHK(ers, 1'b1)
    err_report_en = 1'b0;
    pf(5'h00, 3'h3, 1'b0, 16'h0);
    `CHK(ers, 1'b0)
    bad = 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_hints();
    t_addr();
    t_unc_fault();
    t_err();
    results();
  end
endmodule
